// >>> design/rtfcr_pkg.sv
/*
 * constants for the rail three / rail four control register slice:
 * register offsets, field positions and factory reset tables.
 * assumes one 8-bit register port driven by the host-side interface logic.
 */
package rtfcr_pkg;

    // register offsets
    localparam logic [7:0] ADDR_C_DECAY = 8'h22;
    localparam logic [7:0] ADDR_C_VOLT  = 8'h23;
    localparam logic [7:0] ADDR_C_SLEEP = 8'h24;
    localparam logic [7:0] ADDR_D_CTRL  = 8'h25;

    // field positions
    localparam int CODE_MSB    = 7;
    localparam int CODE_LSB    = 1;
    localparam int C_DECAY_BIT = 0;
    localparam int C_SLPEN_BIT = 0;
    localparam int D_SLPEN_MSB = 5;
    localparam int D_SLPEN_LSB = 4;
    localparam int D_MODE_BIT  = 1;
    localparam int D_DIS_BIT   = 0;

    // readable-bit masks, reserved read-only bits are zero
    localparam logic [7:0] MASK_C_VOLT = 8'hfe;
    localparam logic [7:0] MASK_D_CTRL = 8'h3f;

    // sleep enable encodings of rail d
    localparam logic [1:0] D_SLP_OFF = 2'h0;
    localparam logic [1:0] D_SLP_ON  = 2'h3;

    // sleep pin choices and their positions in the control input bus
    localparam logic       PIN_SEL_THREE = 1'b0;
    localparam logic       PIN_SEL_SIX   = 1'b1;
    localparam int         PIN_THREE_IDX = 2;
    localparam int         PIN_SIX_IDX   = 5;

    // factory reset tables, indexed by variant
    localparam logic [7:0] RST_C_DECAY [4] = '{8'h40, 8'h24, 8'h38, 8'h40};
    localparam logic [7:0] RST_C_VOLT  [4] = '{8'h40, 8'h24, 8'h38, 8'h40};
    localparam logic [7:0] RST_C_SLEEP [4] = '{8'h40, 8'h24, 8'h41, 8'h40};
    localparam logic [7:0] RST_D_CTRL  [4] = '{8'h0f, 8'h3f, 8'h0f, 8'h0f};

    // value returned for an unmapped read
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

endpackage : rtfcr_pkg

// >>> design/rtfcr_regs.sv
/*
 * register bank and output decode for rail three (decay, normal and
 * sleep voltage codes) and rail four (sleep enable, mode, disable).
 * assumes the serial interface front end has turned host transfers into
 * single-cycle write and read strobes synchronous to clk, and that the
 * control input pins are already synchronous to clk.
 */
// Summary of operation
// - decay bit 0: 0 slews actively down, 1 lets the output decay passively.
// - rail three normal voltage code is bits 7:1 of its voltage register.
// - decay register bits 7:1 are spare read/write storage without function.
// - sleep voltage code in bits 7:1 applies only while sleep enable is 1.
// - sleep enable 0 uses normal code; 1 uses sleep code while pin low.
// - each rail has a factory-fixed sleep pin, input three or six, active low.
// - rail four sleep field 5:4: 00 normal always, 11 sleep when pin low.
// - rail four bit 1 selects automatic mode at 0, forced pwm at 1.
// - rail four bit 0 at 0 forces the rail off whatever the pins say.
module rtfcr_regs
    import rtfcr_pkg::*;
#(
    parameter logic [1:0] FACTORY_VARIANT = 2'h0,
    parameter logic       C_SLEEP_PIN     = PIN_SEL_THREE,
    parameter logic       D_SLEEP_PIN     = PIN_SEL_THREE
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    input  wire logic [5:0] controlInputPins,
    input  wire logic       railDPinEnable,
    output logic      [7:0] regRdData,
    output logic            regRdValid,
    output logic      [6:0] railCTargetCode,
    output logic            railCDecayPassive,
    output logic            railCSleepActive,
    output logic            railDSleepActive,
    output logic            railDForcedPwm,
    output logic            railDEnable
);

    logic [7:0] cDecayQ;
    logic [7:0] cVoltQ;
    logic [7:0] cSleepQ;
    logic [7:0] dCtrlQ;
    logic [7:0] rdDataD;
    logic [7:0] rdAddrQ;
    logic       cPinLow;
    logic       dPinLow;
    logic       cSleepSel;
    logic       dSleepSel;
    logic [6:0] cCodeD;

    // picks the factory-assigned sleep pin and reports it low
    function automatic logic sleep_pin_low(input logic [5:0] pins, input logic sel);
        logic lvl;
        lvl = (sel == PIN_SEL_SIX) ? pins[PIN_SIX_IDX] : pins[PIN_THREE_IDX];
        return !lvl;
    endfunction : sleep_pin_low

    // write decode for one register
    function automatic logic wr_hit(input logic en, input logic [7:0] a,
                                    input logic [7:0] target);
        return en && (a == target);
    endfunction : wr_hit

    // rail three decay register, spare bits kept as plain storage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cDecayQ <= RST_C_DECAY[FACTORY_VARIANT];
        end else if (wr_hit(regWrEn, regAddr, ADDR_C_DECAY)) begin
            cDecayQ <= regWrData;
        end
    end

    // rail three voltage register, bit 0 is read-only zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cVoltQ <= RST_C_VOLT[FACTORY_VARIANT] & MASK_C_VOLT;
        end else if (wr_hit(regWrEn, regAddr, ADDR_C_VOLT)) begin
            cVoltQ <= regWrData & MASK_C_VOLT;
        end
    end

    // rail three sleep register: sleep code and sleep enable
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cSleepQ <= RST_C_SLEEP[FACTORY_VARIANT];
        end else if (wr_hit(regWrEn, regAddr, ADDR_C_SLEEP)) begin
            cSleepQ <= regWrData;
        end
    end

    // rail four control; reserved codes are stored as written, the decode
    // below simply treats anything but 11 as sleep disabled
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dCtrlQ <= RST_D_CTRL[FACTORY_VARIANT] & MASK_D_CTRL;
        end else if (wr_hit(regWrEn, regAddr, ADDR_D_CTRL)) begin
            dCtrlQ <= regWrData & MASK_D_CTRL;
        end
    end

    // sleep selection per rail from its factory pin
    assign cPinLow   = sleep_pin_low(controlInputPins, C_SLEEP_PIN);
    assign dPinLow   = sleep_pin_low(controlInputPins, D_SLEEP_PIN);
    assign cSleepSel = cSleepQ[C_SLPEN_BIT] && cPinLow;
    assign dSleepSel = (dCtrlQ[D_SLPEN_MSB:D_SLPEN_LSB] == D_SLP_ON) && dPinLow;

    // target code mux: sleep code only with enable set and pin low
    always_comb begin
        if (cSleepSel) begin
            cCodeD = cSleepQ[CODE_MSB:CODE_LSB];
        end else begin
            cCodeD = cVoltQ[CODE_MSB:CODE_LSB];
        end
    end

    // rail three outputs, registered so the regulator never sees a glitch
    // while the host rewrites a code
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            railCTargetCode   <= 7'h00;
            railCDecayPassive <= 1'b0;
            railCSleepActive  <= 1'b0;
        end else begin
            railCTargetCode   <= cCodeD;
            railCDecayPassive <= cDecayQ[C_DECAY_BIT];
            railCSleepActive  <= cSleepSel;
        end
    end

    // rail four outputs; the disable bit overrides any pin request
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            railDSleepActive <= 1'b0;
            railDForcedPwm   <= 1'b0;
            railDEnable      <= 1'b0;
        end else begin
            railDSleepActive <= dSleepSel;
            railDForcedPwm   <= dCtrlQ[D_MODE_BIT];
            railDEnable      <= dCtrlQ[D_DIS_BIT] && railDPinEnable;
        end
    end

    // read mux, reserved bits come back as zero
    always_comb begin
        unique case (regAddr)
            ADDR_C_DECAY: rdDataD = cDecayQ;
            ADDR_C_VOLT:  rdDataD = cVoltQ & MASK_C_VOLT;
            ADDR_C_SLEEP: rdDataD = cSleepQ;
            ADDR_D_CTRL:  rdDataD = dCtrlQ & MASK_D_CTRL;
            default:      rdDataD = RD_UNMAPPED;
        endcase
    end

    // read answer one cycle after the strobe; a write in the same cycle is
    // not yet visible, which keeps the read path free of a write bypass
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRdData  <= 8'h00;
            regRdValid <= 1'b0;
            rdAddrQ    <= 8'h00;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                regRdData <= rdDataD;
                rdAddrQ   <= regAddr;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // write then read of the same register
    sequence s_wr_decay;
        regWrEn && (regAddr == ADDR_C_DECAY);
    endsequence

    sequence s_rd_decay;
        regRdEn && !regWrEn && (regAddr == ADDR_C_DECAY);
    endsequence

    a_spare_readback: assert property (
        s_wr_decay ##1 s_rd_decay |=> regRdData == $past(regWrData, 2))
        else $error("spare bits did not read back");

    a_rd_latency: assert property (
        regRdEn |=> regRdValid ##0 $past(regRdEn))
        else $error("read answer not one cycle after strobe");

    a_volt_rsvd_zero: assert property (
        regRdValid && (rdAddrQ == ADDR_C_VOLT) |-> regRdData[0] == 1'b0)
        else $error("reserved voltage bit read nonzero");

    a_ctrl_rsvd_zero: assert property (
        regRdValid && (rdAddrQ == ADDR_D_CTRL) |-> regRdData[7:6] == 2'h0)
        else $error("reserved control bits read nonzero");

    a_c_normal_code: assert property (
        !cSleepSel |=>
            railCTargetCode == $past(cVoltQ[CODE_MSB:CODE_LSB]) && !railCSleepActive)
        else $error("rail three not on normal code");

    a_c_sleep_code: assert property (
        cSleepSel |=>
            railCTargetCode == $past(cSleepQ[CODE_MSB:CODE_LSB]) && railCSleepActive)
        else $error("rail three not on sleep code");

    a_c_decay_follow: assert property (
        wr_hit(regWrEn, regAddr, ADDR_C_DECAY) |=> ##1
            railCDecayPassive == $past(regWrData[C_DECAY_BIT], 2))
        else $error("decay output does not follow written bit");

    a_d_sleep_decode: assert property (
        (dCtrlQ[D_SLPEN_MSB:D_SLPEN_LSB] != D_SLP_ON) |=> !railDSleepActive)
        else $error("rail four sleep without enable code 11");

    a_d_mode_follow: assert property (
        wr_hit(regWrEn, regAddr, ADDR_D_CTRL) |=> ##1
            railDForcedPwm == $past(regWrData[D_MODE_BIT], 2))
        else $error("rail four mode does not follow written bit");

    a_d_disable_off: assert property (
        !dCtrlQ[D_DIS_BIT] |=> !railDEnable)
        else $error("rail four on while disable bit is 0");

    // pin index of each rail's factory sleep input, kept apart from the
    // decode function so the checks below do not reuse the logic they watch
    localparam int C_PIN_IDX = (C_SLEEP_PIN == PIN_SEL_SIX) ? PIN_SIX_IDX : PIN_THREE_IDX;
    localparam int D_PIN_IDX = (D_SLEEP_PIN == PIN_SEL_SIX) ? PIN_SIX_IDX : PIN_THREE_IDX;

    // single-cycle writes to the other registers
    sequence s_wr_volt;
        wr_hit(regWrEn, regAddr, ADDR_C_VOLT);
    endsequence

    sequence s_wr_sleep;
        wr_hit(regWrEn, regAddr, ADDR_C_SLEEP);
    endsequence

    sequence s_wr_dctrl;
        wr_hit(regWrEn, regAddr, ADDR_D_CTRL);
    endsequence

    // a write to the decay register lands whole, spare bits included
    a_decay_spare_keep: assert property (
        s_wr_decay |=> cDecayQ == $past(regWrData))
        else $error("decay register did not take the written byte");

    // a new normal code reaches the target one edge after it lands
    a_c_volt_follow: assert property (
        s_wr_volt ##1 !cSleepSel |=>
            railCTargetCode == $past(regWrData[CODE_MSB:CODE_LSB], 2))
        else $error("rail three target missed the written normal code");

    // a new sleep code reaches the target while sleep is selected
    a_c_slp_follow: assert property (
        s_wr_sleep ##1 cSleepSel |=>
            railCTargetCode == $past(regWrData[CODE_MSB:CODE_LSB], 2))
        else $error("rail three target missed the written sleep code");

    // sleep enable clear keeps rail three on its normal code
    a_c_sleep_off: assert property (
        !cSleepQ[C_SLPEN_BIT] |=>
            !railCSleepActive && railCTargetCode == $past(cVoltQ[CODE_MSB:CODE_LSB]))
        else $error("rail three left its normal code without sleep enable");

    // enable set and the factory pin low select the sleep code
    a_c_pin_sleep: assert property (
        cSleepQ[C_SLPEN_BIT] && !controlInputPins[C_PIN_IDX] |=>
            railCSleepActive && railCTargetCode == $past(cSleepQ[CODE_MSB:CODE_LSB]))
        else $error("rail three not in sleep with enable set and pin low");

    // a high factory pin never puts rail three to sleep
    a_c_pin_high: assert property (
        controlInputPins[C_PIN_IDX] |=> !railCSleepActive)
        else $error("rail three asleep with its sleep pin high");

    // code 11 and the factory pin low put rail four to sleep
    a_d_pin_sleep: assert property (
        (dCtrlQ[D_SLPEN_MSB:D_SLPEN_LSB] == D_SLP_ON) && !controlInputPins[D_PIN_IDX]
            |=> railDSleepActive)
        else $error("rail four not in sleep with code 11 and pin low");

    // a high factory pin never puts rail four to sleep
    a_d_pin_high: assert property (
        controlInputPins[D_PIN_IDX] |=> !railDSleepActive)
        else $error("rail four asleep with its sleep pin high");

    // a written 0 in the disable bit turns the rail off two edges later
    a_d_disable_wr: assert property (
        s_wr_dctrl ##0 !regWrData[D_DIS_BIT] |=> ##1 !railDEnable)
        else $error("rail four stayed on after disable write");

    // disable bit 1 and the pin request together turn rail four on
    a_d_enable_on: assert property (
        dCtrlQ[D_DIS_BIT] && railDPinEnable |=> railDEnable)
        else $error("rail four off with disable bit 1 and pin request");

    // reserved top bits of rail four stay zero whatever is written
    a_ctrl_wr_mask: assert property (
        s_wr_dctrl |=> (dCtrlQ & ~MASK_D_CTRL) == 8'h00)
        else $error("rail four reserved bits took a write");

endmodule : rtfcr_regs

// >>> verification/rtfcr_host_model.sv
/* host partner model: one-cycle write and read strobes on the register port.
   assumes rtfcr_regs port timing; drives 1 ns after each rising clk edge. */
module rtfcr_host_model
    import rtfcr_pkg::*;
(
    input  wire logic       clk,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWrData,
    output logic            regWrEn,
    output logic            regRdEn,
    input  wire logic [7:0] regRdData,
    input  wire logic       regRdValid
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle port at time zero
    initial begin
        {regAddr, regWrData, regWrEn, regRdEn} = '0;
    end

    // strobe one write; address and data go to their inverse once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == ADDR_D_CTRL) begin
            d[3:2] = 2'h3;
            if (d[5] != d[4]) d[5:4] = D_SLP_OFF;
        end
        @(posedge clk);
        #1;
        {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
        @(posedge clk);
        #1;
        {regAddr, regWrData, regWrEn} = {~a, ~d, 1'b0};
    endtask : wr

    // strobe one read; data and valid are taken one cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk);
        #1;
        {regAddr, regRdEn} = {a, 1'b1};
        @(posedge clk);
        #1;
        {regAddr, regRdEn} = {~a, 1'b0};
        ok = regRdValid;
        d  = regRdData;
    endtask : rd

    // write, then read the same offset; same=1 reads in the write cycle itself,
    // otherwise the read strobe follows on the very next cycle
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic same,
                         output logic [7:0] q, output logic ok);
        if (a == ADDR_D_CTRL) begin
            d[3:2] = 2'h3;
            if (d[5] != d[4]) d[5:4] = D_SLP_OFF;
        end
        @(posedge clk);
        #1;
        {regAddr, regWrData, regWrEn, regRdEn} = {a, d, 1'b1, same};
        if (!same) begin
            @(posedge clk);
            #1;
            {regWrData, regWrEn, regRdEn} = {~d, 1'b0, 1'b1};
        end
        @(posedge clk);
        #1;
        {regAddr, regWrData, regWrEn, regRdEn} = {~a, ~d, 1'b0, 1'b0};
        ok = regRdValid;
        q  = regRdData;
    endtask : wr_rd
endmodule : rtfcr_host_model

// >>> verification/rail_three_four_ctrl_regs_tb.sv
/* self-checking bench for rtfcr_regs: variant 0 with pin three, and a second
   unit on variant 2 with pin six for both rails, sharing every input.
   assumes the host model drives the register port; the bench drives the pins. */
module rail_three_four_ctrl_regs_tb
    import rtfcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic [7:0] regAddr, regWrData, regRdData;
    logic       regWrEn, regRdEn, regRdValid, railDPinEnable = 1'b1;
    logic [5:0] controlInputPins = 6'h3f;
    logic [6:0] railCTargetCode;
    logic       railCDecayPassive, railCSleepActive, railDSleepActive;
    logic       railDForcedPwm, railDEnable;
    logic [6:0] altCode;
    logic       altDecay, altCSleep, altDSleep, altPwm, altEnable;
    int         fails = 0;
    int         totalChecks = 0;

    always #50 clk = ~clk;

    rtfcr_regs uut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .controlInputPins(controlInputPins),
        .railDPinEnable(railDPinEnable), .regRdData(regRdData), .regRdValid(regRdValid),
        .railCTargetCode(railCTargetCode), .railCDecayPassive(railCDecayPassive),
        .railCSleepActive(railCSleepActive), .railDSleepActive(railDSleepActive),
        .railDForcedPwm(railDForcedPwm), .railDEnable(railDEnable));

    rtfcr_host_model host (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid));

    // second unit on the other factory table and pin six for both rails
    rtfcr_regs #(.FACTORY_VARIANT(2'h2), .C_SLEEP_PIN(PIN_SEL_SIX), .D_SLEEP_PIN(PIN_SEL_SIX))
        uut2 (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .controlInputPins(controlInputPins),
        .railDPinEnable(railDPinEnable), .regRdData(), .regRdValid(),
        .railCTargetCode(altCode), .railCDecayPassive(altDecay),
        .railCSleepActive(altCSleep), .railDSleepActive(altDSleep),
        .railDForcedPwm(altPwm), .railDEnable(altEnable));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        host.rd(a, d, ok);
        chk("read valid", {7'h0, ok}, 8'h01);
        chk("read data", d, exp);
    endtask : rdchk

    // outputs follow a register or pin change one edge after it lands
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    // rail outputs in two bytes: target code, then the five flags
    task automatic outs(input logic [6:0] code, input logic [4:0] flags);
        chk("target code", {1'b0, railCTargetCode}, {1'b0, code});
        chk("flags", {3'h0, railCDecayPassive, railCSleepActive, railDSleepActive,
            railDForcedPwm, railDEnable}, {3'h0, flags});
    endtask : outs

    // same layout for the second unit
    task automatic alt_outs(input logic [6:0] code, input logic [4:0] flags);
        chk("alt target code", {1'b0, altCode}, {1'b0, code});
        chk("alt flags", {3'h0, altDecay, altCSleep, altDSleep, altPwm, altEnable},
            {3'h0, flags});
    endtask : alt_outs

    task automatic t_reset();
        settle();
        outs(7'h20, 5'b00011);
        alt_outs(7'h1c, 5'b00011);
        rdchk(ADDR_C_DECAY, 8'h40);
        rdchk(ADDR_C_VOLT, 8'h40);
        rdchk(ADDR_C_SLEEP, 8'h40);
        rdchk(ADDR_D_CTRL, 8'h0f);
        rdchk(8'h26, RD_UNMAPPED);
        controlInputPins = 6'h1f;
        settle();
        outs(7'h20, 5'b00011);
        alt_outs(7'h20, 5'b01011);
        controlInputPins = 6'h3f;
    endtask : t_reset

    // a read in the write cycle returns the old byte, one right after the new
    task automatic t_b2b();
        logic [7:0] q;
        logic       ok;
        host.wr_rd(ADDR_C_DECAY, 8'ha5, 1'b1, q, ok);
        chk("same-cycle valid", {7'h0, ok}, 8'h01);
        chk("same-cycle data", q, 8'h54);
        host.wr_rd(ADDR_C_DECAY, 8'h5a, 1'b0, q, ok);
        chk("next-cycle valid", {7'h0, ok}, 8'h01);
        chk("next-cycle data", q, 8'h5a);
        @(posedge clk);
        #1;
        chk("valid pulse", {7'h0, regRdValid}, 8'h00);
    endtask : t_b2b

    // a second reset mid-run must bring back the factory contents
    task automatic t_mid_reset();
        controlInputPins = 6'h3f;
        railDPinEnable   = 1'b1;
        nrst             = 1'b0;
        @(posedge clk);
        #1;
        outs(7'h00, 5'b00000);
        @(posedge clk);
        #1;
        nrst = 1'b1;
        t_reset();
    endtask : t_mid_reset

    task automatic t_decay();
        host.wr(ADDR_C_DECAY, 8'hab);
        settle();
        outs(7'h20, 5'b10011);
        rdchk(ADDR_C_DECAY, 8'hab);
        host.wr(ADDR_C_DECAY, 8'h54);
        settle();
        outs(7'h20, 5'b00011);
    endtask : t_decay

    // sleep code only with enable set and pin three low
    task automatic t_rail_c();
        host.wr(ADDR_C_VOLT, 8'hff);
        rdchk(ADDR_C_VOLT, 8'hfe);
        host.wr(ADDR_C_SLEEP, 8'h2b);
        settle();
        outs(7'h7f, 5'b00011);
        controlInputPins = 6'h1f;
        settle();
        outs(7'h7f, 5'b00011);
        alt_outs(7'h15, 5'b01011);
        controlInputPins = 6'h3b;
        settle();
        outs(7'h15, 5'b01011);
        alt_outs(7'h7f, 5'b00011);
        host.wr(ADDR_C_SLEEP, 8'h37);
        settle();
        outs(7'h1b, 5'b01011);
        host.wr(ADDR_C_SLEEP, 8'h2a);
        settle();
        outs(7'h7f, 5'b00011);
    endtask : t_rail_c

    // pin three still low here
    task automatic t_rail_d();
        host.wr(ADDR_D_CTRL, 8'h32);
        settle();
        outs(7'h7f, 5'b00110);
        alt_outs(7'h7f, 5'b00010);
        rdchk(ADDR_D_CTRL, 8'h3e);
        host.wr(ADDR_D_CTRL, 8'hc1);
        settle();
        outs(7'h7f, 5'b00001);
        rdchk(ADDR_D_CTRL, 8'h0d);
        railDPinEnable = 1'b0;
        settle();
        outs(7'h7f, 5'b00000);
    endtask : t_rail_d

    initial begin
        repeat (6) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_reset();
        t_decay();
        t_b2b();
        t_rail_c();
        t_rail_d();
        t_mid_reset();
        report_and_stop();
    end

    // hang guard
    initial begin
        #1000000;
        fails++;
        report_and_stop();
    end
endmodule : rail_three_four_ctrl_regs_tb
